// ---- verilog/thermal_overload_defines.svh ----
// Constants of the thermal overload output stage: reset values, limits, timing
`ifndef THERMAL_OVERLOAD_DEFINES_SVH
`define THERMAL_OVERLOAD_DEFINES_SVH

// Clock rate and program cycle timing
`define CLOCK_MHZ            100
`define PROG_CYCLE_US        5000
`define PROG_CYCLE_CYCLES    (`PROG_CYCLE_US * `CLOCK_MHZ)
// Least lead of blocking before the operate delay expires
`define BLOCK_LEAD_MS        5
`define BLOCK_LEAD_CYCLES    (`BLOCK_LEAD_MS * 1000 * `CLOCK_MHZ)

// Threshold reset values, in 0.1 % of thermal capacity
`define ALARM1_LEVEL_RST     16'h0190
`define ALARM2_LEVEL_RST     16'h0190
`define INHIBIT_LEVEL_RST    16'h0320
`define TRIP_LEVEL_RST       16'h03e8
`define LEVEL_MAX            16'h05dc

// Extra trip delay, in program cycles of 5 ms
`define TRIP_DELAY_RST       20'h00000
`define TRIP_DELAY_MAX       20'hafc80

// Factor settings, in units of 0.01, and ambient temperature reset values
`define FACTOR_UNITY         16'h0064
`define FACTOR_MIN           16'h0001
`define FACTOR_MAX           16'h01f4
`define AMB_MAX_TEMP_RST     16'h002d
`define AMB_MIN_TEMP_RST     16'h0000

// Load classes, current in 0.001 x nominal
`define LIGHT_LOAD_LIMIT     16'h000a
`define HIGH_OVERLOAD_LIMIT  16'h07d0

`endif

// ---- verilog/thermal_overload_pkg.sv ----
// Types shared by the thermal overload output stage
package thermal_overload_pkg;

  // Reported operating condition
  typedef enum logic [2:0] {
    cond_normal,
    cond_alarm1_on,
    cond_alarm2_on,
    cond_inhibit_on,
    cond_trip_on,
    cond_blocked
  } operating_condition_e;

  // Reported load class
  typedef enum logic [1:0] {
    load_light,
    load_normal,
    load_overloading,
    load_high_overload
  } load_class_e;

  // One parameter set of the stage
  typedef struct packed {
    logic               en_alarm1;
    logic               en_alarm2;
    logic               en_inhibit;
    logic               en_trip;
    logic [15:0]        alarm1_level;
    logic [15:0]        alarm2_level;
    logic [15:0]        restart_inhibit_threshold;
    logic [15:0]        trip_level;
    logic [19:0]        extra_trip_delay;
    logic [15:0]        service_factor;
    logic [15:0]        k_max_amb;
    logic [15:0]        k_min_amb;
    logic signed [15:0] max_amb_temp;
    logic signed [15:0] min_amb_temp;
    logic [15:0]        nominal_scale;
  } settings_s;

  // Setting fault flags, each high only while its fault stands
  typedef struct packed {
    logic service_factor_fault;
    logic ambient_fault;
    logic nominal_current_fault;
    logic ambient_k_inconsistent;
  } setting_fault_flag_s;

  // Factors actually used after fallback to unity
  typedef struct packed {
    logic [15:0] service_factor;
    logic [15:0] k_max_amb;
    logic [15:0] k_min_amb;
    logic [15:0] nominal_scale;
  } used_factors_s;

  // Protection outputs towards the I/O logic
  typedef struct packed {
    logic alarm1;
    logic alarm2;
    logic restart_inhibit;
    logic trip;
    logic start;
    logic blocked;
  } stage_outputs_s;

endpackage

// ---- verilog/setting_check.sv ----
// Range check of one factor setting with fallback to a fixed value
`timescale 1ns/10ps
module setting_check #(
  parameter int          WIDTH    = 16,
  parameter logic [15:0] LO       = 16'h0001,
  parameter logic [15:0] HI       = 16'h01f4,
  parameter logic [15:0] FALLBACK = 16'h0064
) (
  // Setting under test
  input  wire logic [WIDTH-1:0] value,
  // Verdict and value to use
  output      logic             fault,
  output      logic [WIDTH-1:0] used
);

  // Out of range values are replaced, never clamped, so the fault is obvious
  assign fault = (value < LO[WIDTH-1:0]) || (value > HI[WIDTH-1:0]);
  assign used  = fault ? FALLBACK[WIDTH-1:0] : value;

  // Refuse widths the limit constants cannot describe
  if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
    $error("setting_check: WIDTH must be 1 to 16");
  end

endmodule // setting_check

// ---- verilog/thermal_overload_stage.sv ----
// Output and supervision stage of the thermal overload protection
`timescale 1ns/10ps
`include "thermal_overload_defines.svh"

module thermal_overload_stage #(
  parameter int          PROG_CYCLE_CYCLES = `PROG_CYCLE_CYCLES,
  parameter int          DELAY_WIDTH       = 20,
  parameter int          VALUE_WIDTH       = 16
) (
  // Clock and reset
  input  wire logic                                        clock,
  input  wire logic                                        rst_n,
  // Thermal image results, same clock domain
  input  wire logic [VALUE_WIDTH-1:0]                      thermal_capacity,
  input  wire logic [VALUE_WIDTH-1:0]                      measured_current,
  input  wire logic [VALUE_WIDTH-1:0]                      pickup_current,
  // Active setting group, same clock domain
  input  wire thermal_overload_pkg::settings_s             settings,
  // Blocking from the blocking matrix, asynchronous pin
  input  wire logic                                        block_in,
  // Protection outputs
  output      thermal_overload_pkg::stage_outputs_s        outputs,
  // Status reporting
  output      thermal_overload_pkg::operating_condition_e  operating_condition,
  output      thermal_overload_pkg::load_class_e           load_class,
  output      thermal_overload_pkg::setting_fault_flag_s   setting_fault_flag,
  output      thermal_overload_pkg::used_factors_s         used_factors,
  output      logic [DELAY_WIDTH-1:0]                      trip_delay_count,
  output      logic                                        program_tick
);

  // Pick-up sequencing states
  typedef enum logic [1:0] {
    st_idle,
    st_started,
    st_blocked
  } pickup_state_e;

  localparam int TICK_WIDTH = 20;

  // Elaboration check of the parameters
  if (PROG_CYCLE_CYCLES < 2 || PROG_CYCLE_CYCLES > (2 ** TICK_WIDTH)) begin : g_cycle_check
    $error("thermal_overload_stage: PROG_CYCLE_CYCLES out of range");
  end
  if (DELAY_WIDTH < 20 || VALUE_WIDTH != 16) begin : g_width_check
    $error("thermal_overload_stage: unsupported DELAY_WIDTH or VALUE_WIDTH");
  end

  localparam logic [TICK_WIDTH-1:0] TICK_LAST = TICK_WIDTH'(PROG_CYCLE_CYCLES - 1);

  // Program cycle timebase
  logic [TICK_WIDTH-1:0] tick_count;
  logic [TICK_WIDTH-1:0] next_tick_count;
  wire                   tick_wrap = (tick_count == TICK_LAST);

  assign next_tick_count = tick_wrap ? '0 : TICK_WIDTH'(tick_count + 1'b1);

  // Free running divider; every decision except the setting supervision, which runs every clock, is taken on its wrap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_count   <= '0;
      program_tick <= 1'b0;
    end else begin
      tick_count   <= next_tick_count;
      program_tick <= tick_wrap;
    end
  end

  // Blocking input: synchroniser, then one sample per program cycle
  logic block_meta;
  logic block_sync;
  logic block_sampled;

  // Two stages against metastability; first stage read only by the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      block_meta <= 1'b0;
      block_sync <= 1'b0;
    end else begin
      block_meta <= block_in;
      block_sync <= block_meta;
    end
  end

  // Blocking is frozen for the whole program cycle so one cycle sees one value
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      block_sampled <= 1'b0;
    end else if (tick_wrap) begin
      block_sampled <= block_sync;
    end
  end

  // Setting group capture
  thermal_overload_pkg::settings_s active;

  localparam thermal_overload_pkg::settings_s SETTINGS_RST = '{
    en_alarm1                 : 1'b0,
    en_alarm2                 : 1'b0,
    en_inhibit                : 1'b0,
    en_trip                   : 1'b0,
    alarm1_level              : `ALARM1_LEVEL_RST,
    alarm2_level              : `ALARM2_LEVEL_RST,
    restart_inhibit_threshold : `INHIBIT_LEVEL_RST,
    trip_level                : `TRIP_LEVEL_RST,
    extra_trip_delay          : `TRIP_DELAY_RST,
    service_factor            : `FACTOR_UNITY,
    k_max_amb                 : `FACTOR_UNITY,
    k_min_amb                 : `FACTOR_UNITY,
    max_amb_temp              : `AMB_MAX_TEMP_RST,
    min_amb_temp              : `AMB_MIN_TEMP_RST,
    nominal_scale             : `FACTOR_UNITY
  };

  // A group change is taken at a cycle boundary, never in mid evaluation
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active <= SETTINGS_RST;
    end else if (tick_wrap) begin
      active <= settings;
    end
  end

  // Delay beyond the documented maximum is clamped to it
  wire [DELAY_WIDTH-1:0] delay_limit =
    (active.extra_trip_delay > `TRIP_DELAY_MAX) ? DELAY_WIDTH'(`TRIP_DELAY_MAX)
                                                : DELAY_WIDTH'(active.extra_trip_delay);

  // Threshold comparisons
  wire alarm1_cmp  = active.en_alarm1 &&
                     (thermal_capacity >= active.alarm1_level);
  wire alarm2_cmp  = active.en_alarm2 &&
                     (thermal_capacity >= active.alarm2_level);
  wire inhibit_cmp = active.en_inhibit &&
                     (thermal_capacity >= active.restart_inhibit_threshold);
  wire pickup      = active.en_trip &&
                     (thermal_capacity >= active.trip_level);

  // Pick-up, blocking and extra trip delay sequencing
  pickup_state_e         state;
  pickup_state_e         next_state;
  logic [DELAY_WIDTH-1:0] next_count;
  logic                  next_trip;

  // Decided on each program cycle wrap; idle cycles only hold
  always_comb begin
    next_state = state;
    next_count = trip_delay_count;
    case (state)
      st_idle: begin
        next_count = '0;
        if (pickup && !block_sampled) begin
          next_state = st_started;
        end else if (pickup && block_sampled) begin
          next_state = st_blocked;
        end
      end
      st_started: begin
        if (!pickup) begin
          next_state = st_idle;
          next_count = '0;
        end else if (block_sampled) begin
          next_state = st_blocked;
          next_count = '0;
        end else if (trip_delay_count < delay_limit) begin
          next_count = DELAY_WIDTH'(trip_delay_count + 1'b1);
        end
      end
      st_blocked: begin
        // Nothing is timed here; leave once pick-up or blocking is gone
        next_count = '0;
        if (!pickup || !block_sampled) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
        next_count = '0;
      end
    endcase
  end

  // Zero delay trips in the same cycle that start is raised
  assign next_trip = (next_state == st_started) && (next_count >= delay_limit);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state            <= st_idle;
      trip_delay_count <= '0;
    end else if (tick_wrap) begin
      state            <= next_state;
      trip_delay_count <= next_count;
    end
  end

  // Protection outputs, updated once per program cycle
  thermal_overload_pkg::stage_outputs_s next_outputs;

  assign next_outputs.alarm1          = alarm1_cmp;
  assign next_outputs.alarm2          = alarm2_cmp;
  assign next_outputs.restart_inhibit = inhibit_cmp;
  assign next_outputs.trip            = next_trip;
  assign next_outputs.start           = (next_state == st_started);
  assign next_outputs.blocked         = (next_state == st_blocked);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      outputs <= '0;
    end else if (tick_wrap) begin
      outputs <= next_outputs;
    end
  end

  // Operating condition, most severe first
  thermal_overload_pkg::operating_condition_e next_condition;

  // Normal is reported only when no output other than start is driven
  assign next_condition =
    next_outputs.trip            ? thermal_overload_pkg::cond_trip_on    :
    next_outputs.blocked         ? thermal_overload_pkg::cond_blocked    :
    next_outputs.restart_inhibit ? thermal_overload_pkg::cond_inhibit_on :
    next_outputs.alarm2          ? thermal_overload_pkg::cond_alarm2_on  :
    next_outputs.alarm1          ? thermal_overload_pkg::cond_alarm1_on  :
                                   thermal_overload_pkg::cond_normal;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      operating_condition <= thermal_overload_pkg::cond_normal;
    end else if (tick_wrap) begin
      operating_condition <= next_condition;
    end
  end

  // Load classification from the measured current
  thermal_overload_pkg::load_class_e next_load;
  wire is_light = (measured_current < `LIGHT_LOAD_LIMIT);
  wire is_high  = (measured_current > `HIGH_OVERLOAD_LIMIT);
  wire is_over  = (measured_current > pickup_current);

  // Light wins over the rest so a current below the light limit never reads as overload, even with a zero pick-up
  assign next_load =
    is_light ? thermal_overload_pkg::load_light         :
    is_high  ? thermal_overload_pkg::load_high_overload :
    is_over  ? thermal_overload_pkg::load_overloading   :
               thermal_overload_pkg::load_normal;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      load_class <= thermal_overload_pkg::load_light;
    end else if (tick_wrap) begin
      load_class <= next_load;
    end
  end

  // Setting supervision with fallback to unity
  logic        sf_fault;
  logic        kmax_fault;
  logic        kmin_fault;
  logic        nom_fault;
  logic [15:0] sf_used;
  logic [15:0] kmax_used;
  logic [15:0] kmin_used;
  logic [15:0] nom_used;

  setting_check #(
    .WIDTH    (16),
    .LO       (`FACTOR_MIN),
    .HI       (`FACTOR_MAX),
    .FALLBACK (`FACTOR_UNITY)
  ) u_check_sf (
    .value (active.service_factor),
    .fault (sf_fault),
    .used  (sf_used)
  );

  setting_check #(
    .WIDTH    (16),
    .LO       (`FACTOR_MIN),
    .HI       (`FACTOR_MAX),
    .FALLBACK (`FACTOR_UNITY)
  ) u_check_kmax (
    .value (active.k_max_amb),
    .fault (kmax_fault),
    .used  (kmax_used)
  );

  setting_check #(
    .WIDTH    (16),
    .LO       (`FACTOR_MIN),
    .HI       (`FACTOR_MAX),
    .FALLBACK (`FACTOR_UNITY)
  ) u_check_kmin (
    .value (active.k_min_amb),
    .fault (kmin_fault),
    .used  (kmin_used)
  );

  setting_check #(
    .WIDTH    (16),
    .LO       (`FACTOR_MIN),
    .HI       (`FACTOR_MAX),
    .FALLBACK (`FACTOR_UNITY)
  ) u_check_nom (
    .value (active.nominal_scale),
    .fault (nom_fault),
    .used  (nom_used)
  );

  // Either ambient factor bad forces both to unity, keeping the curve flat
  wire amb_fault    = kmax_fault || kmin_fault;
  wire amb_inconsis = (active.max_amb_temp <= active.min_amb_temp);

  thermal_overload_pkg::setting_fault_flag_s next_flags;
  thermal_overload_pkg::used_factors_s       next_used;

  assign next_flags.service_factor_fault   = sf_fault;
  assign next_flags.ambient_fault          = amb_fault;
  assign next_flags.nominal_current_fault  = nom_fault;
  assign next_flags.ambient_k_inconsistent = amb_inconsis;

  assign next_used.service_factor = sf_used;
  assign next_used.k_max_amb      = amb_fault ? `FACTOR_UNITY : kmax_used;
  assign next_used.k_min_amb      = amb_fault ? `FACTOR_UNITY : kmin_used;
  assign next_used.nominal_scale  = nom_used;

  // Flags follow the fault every cycle; nothing latches them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      setting_fault_flag <= '0;
      used_factors       <= '{default: `FACTOR_UNITY};
    end else begin
      setting_fault_flag <= next_flags;
      used_factors       <= next_used;
    end
  end

  // The blocking source owes a lead of BLOCK_LEAD_MS; a late block is
  // only sampled at the next program cycle wrap and acted on at the wrap after that

endmodule // thermal_overload_stage

// ---- test/thermal_overload_stage_asserts.sv ----
// Assertion checker for the thermal overload output stage
`timescale 1ns/10ps
`include "thermal_overload_defines.svh"
module thermal_overload_stage_asserts #(
  parameter int PROG_CYCLE_CYCLES = 20
) (
  // Clock and reset
  input wire logic                                       clock,
  input wire logic                                       rst_n,
  // Observed stage ports
  input wire logic [15:0]                                measured_current,
  input wire thermal_overload_pkg::stage_outputs_s       outputs,
  input wire thermal_overload_pkg::operating_condition_e operating_condition,
  input wire thermal_overload_pkg::load_class_e          load_class,
  input wire thermal_overload_pkg::setting_fault_flag_s  setting_fault_flag,
  input wire thermal_overload_pkg::used_factors_s        used_factors,
  input wire logic [19:0]                                trip_delay_count,
  input wire logic                                       program_tick
);
  int   gap;
  logic seen;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Clocks since last tick; the first tick after reset has no reference
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap  <= 0;
      seen <= 1'b0;
    end else if (program_tick) begin
      gap  <= 0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 1;
    end
  end

  // Program cycle in which a started stage stays started, not yet tripped
  sequence still_started;
    program_tick && outputs.start && $past(outputs.start) && !outputs.trip;
  endsequence

  tick_period_a: assert property (program_tick && seen |-> gap == PROG_CYCLE_CYCLES - 1)
    else $error("program tick period wrong");
  outs_hold_a: assert property (!program_tick |-> $stable(outputs))
    else $error("outputs moved between program cycles");
  normal_quiet_a: assert property (operating_condition == thermal_overload_pkg::cond_normal
    |-> !(outputs.alarm1 | outputs.alarm2 | outputs.restart_inhibit | outputs.trip))
    else $error("output driven in normal condition");
  trip_cond_a: assert property (outputs.trip |->
    operating_condition == thermal_overload_pkg::cond_trip_on && outputs.start)
    else $error("trip without start or trip condition");
  start_block_a: assert property (outputs.blocked |-> !outputs.start)
    else $error("start and blocked together");
  idle_count_a: assert property (!outputs.start |-> trip_delay_count == 20'h00000)
    else $error("delay count kept while not started");
  count_step_a: assert property (still_started |->
    trip_delay_count == $past(trip_delay_count) + 20'h00001)
    else $error("delay count did not step by one");
  light_load_a: assert property (program_tick |-> (load_class == thermal_overload_pkg::load_light)
    == ($past(measured_current) < `LIGHT_LOAD_LIMIT))
    else $error("light load class wrong");
  sf_unity_a: assert property (setting_fault_flag.service_factor_fault |->
    used_factors.service_factor == `FACTOR_UNITY)
    else $error("faulty service factor not replaced by unity");
endmodule // thermal_overload_stage_asserts

bind thermal_overload_stage thermal_overload_stage_asserts #(
  .PROG_CYCLE_CYCLES(PROG_CYCLE_CYCLES)
) thermal_overload_stage_asserts_inst (
  .clock, .rst_n, .measured_current, .outputs, .operating_condition, .load_class,
  .setting_fault_flag, .used_factors, .trip_delay_count, .program_tick
);

// ---- test/block_matrix_model.sv ----
// Blocking matrix and output I/O model at the far side of the stage
`timescale 1ns/10ps
module block_matrix_model (
  // Clock
  input wire logic                                 clock,
  // Bench request and stage outputs
  input wire logic                                 block_req,
  input wire thermal_overload_pkg::stage_outputs_s outputs,
  // Blocking line and count of trip operations
  output     logic                                 block_in,
  output     int                                   trip_count
);
  logic trip_seen;

  initial begin
    block_in   = 1'b0;
    trip_count = 0;
    trip_seen  = 1'b0;
  end

  // Bench raises requests whole program cycles ahead, well over the lead
  always @(posedge clock) begin
    block_in <= block_req;
  end

  // I/O side counts each rising trip, as a breaker would see it
  always @(posedge clock) begin
    trip_seen <= outputs.trip;
    if (outputs.trip && !trip_seen) begin
      trip_count <= trip_count + 1;
    end
  end
endmodule // block_matrix_model

// ---- test/thermal_overload_stage_bench.sv ----
// Self-checking testbench of the thermal overload output stage
`timescale 1ns/10ps
`include "thermal_overload_defines.svh"
module thermal_overload_stage_bench;
  logic                                       clock = 1'b0;
  logic                                       rst_n = 1'b0;
  logic [15:0]                                thermal_capacity = 16'h0000;
  logic [15:0]                                measured_current = 16'h0000;
  logic [15:0]                                pickup_current = 16'h03e8;
  logic                                       block_req = 1'b0;
  logic                                       block_in;
  thermal_overload_pkg::settings_s            settings;
  thermal_overload_pkg::stage_outputs_s       outputs;
  thermal_overload_pkg::operating_condition_e operating_condition;
  thermal_overload_pkg::load_class_e          load_class;
  thermal_overload_pkg::setting_fault_flag_s  setting_fault_flag;
  thermal_overload_pkg::used_factors_s        used_factors;
  logic [19:0]                                trip_delay_count;
  logic                                       program_tick;
  int                                         trip_count;
  int                                         num_errors = 0;
  int                                         compares = 0;

  // Short program cycle keeps the run brief
  thermal_overload_stage #(.PROG_CYCLE_CYCLES(20)) thermal_overload_stage_inst (
    .clock, .rst_n, .thermal_capacity, .measured_current, .pickup_current, .settings,
    .block_in, .outputs, .operating_condition, .load_class, .setting_fault_flag,
    .used_factors, .trip_delay_count, .program_tick
  );
  block_matrix_model block_matrix_model_inst (
    .clock, .block_req, .outputs, .block_in, .trip_count
  );

  always #5 clock = ~clock;

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Waits n program ticks, returning just after the last tick cycle
  task automatic ticks(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clock);
        #1;
        k++;
      end while (program_tick !== 1'b1 && k < 40);
      chk("program_tick", 1'b1, program_tick);
    end
  endtask

  task automatic report_and_stop;
    $display("Compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic t_reset;
    chk("outputs", 6'h00, outputs);
    chk("cond", thermal_overload_pkg::cond_normal, operating_condition);
    chk("used", {4{`FACTOR_UNITY}}, used_factors);
    rst_n = 1'b1;
    $display("Test reset done");
  endtask

  // Descending capacity also shows each output dropping below its level
  task automatic t_alarms;
    logic [15:0] lv [4] = '{16'h0320, 16'h01f4, 16'h0190, 16'h018f};
    settings.en_alarm1 = 1'b1;
    settings.en_alarm2 = 1'b1;
    settings.en_inhibit = 1'b1;
    settings.alarm2_level = 16'h01f4;
    for (int i = 0; i < 4; i++) begin
      thermal_capacity = lv[i];
      ticks(3);
      chk("alarm1", lv[i] >= 16'h0190, outputs.alarm1);
      chk("alarm2", lv[i] >= 16'h01f4, outputs.alarm2);
      chk("inhibit", lv[i] >= 16'h0320, outputs.restart_inhibit);
    end
    chk("cond", thermal_overload_pkg::cond_normal, operating_condition);
    settings.en_alarm1 = 1'b0;
    thermal_capacity = 16'h0320;
    ticks(3);
    chk("alarm1", 1'b0, outputs.alarm1);
    chk("cond", thermal_overload_pkg::cond_inhibit_on, operating_condition);
    $display("Test alarms done");
  endtask

  task automatic t_trip;
    settings.en_trip = 1'b1;
    settings.extra_trip_delay = 20'h00002;
    thermal_capacity = 16'h03e7;
    ticks(3);
    chk("start", 1'b0, outputs.start);
    thermal_capacity = 16'h03e8;
    ticks(1);
    chk("start", 1'b1, outputs.start);
    chk("trip", 1'b0, outputs.trip);
    ticks(1);
    chk("count", 20'h00001, trip_delay_count);
    thermal_capacity = 16'h03e7;
    ticks(1);
    chk("count", 20'h00000, trip_delay_count);
    thermal_capacity = 16'h03e8;
    ticks(2);
    chk("trip", 1'b0, outputs.trip);
    ticks(1);
    chk("trip", 1'b1, outputs.trip);
    chk("cond", thermal_overload_pkg::cond_trip_on, operating_condition);
    thermal_capacity = 16'h03e7;
    settings.extra_trip_delay = 20'h00000;
    ticks(3);
    thermal_capacity = 16'h03e8;
    ticks(1);
    chk("trip", 1'b1, outputs.trip);
    thermal_capacity = 16'h03e7;
    settings.extra_trip_delay = 20'h00005;
    ticks(3);
    chk("trips", 2, trip_count);
    $display("Test trip done");
  endtask

  task automatic t_block;
    block_req = 1'b1;
    ticks(4);
    thermal_capacity = 16'h03e8;
    ticks(1);
    chk("blocked", 1'b1, outputs.blocked);
    chk("cond", thermal_overload_pkg::cond_blocked, operating_condition);
    ticks(6);
    chk("trip", 1'b0, outputs.trip);
    block_req = 1'b0;
    thermal_capacity = 16'h03e7;
    ticks(4);
    thermal_capacity = 16'h03e8;
    ticks(1);
    chk("start", 1'b1, outputs.start);
    block_req = 1'b1;
    ticks(4);
    chk("start", 1'b0, outputs.start);
    chk("count", 20'h00000, trip_delay_count);
    chk("trip", 1'b0, outputs.trip);
    block_req = 1'b0;
    thermal_capacity = 16'h0000;
    ticks(4);
    $display("Test block done");
  endtask

  // Boundaries around the light, pick-up and twice-nominal limits
  task automatic t_load;
    logic [15:0] cur [6] = '{16'h0009, 16'h000a, 16'h03e8, 16'h03e9, 16'h07d0, 16'h07d1};
    logic [1:0]  cls [6];
    cls = '{thermal_overload_pkg::load_light, thermal_overload_pkg::load_normal,
            thermal_overload_pkg::load_normal, thermal_overload_pkg::load_overloading,
            thermal_overload_pkg::load_overloading, thermal_overload_pkg::load_high_overload};
    for (int i = 0; i < 6; i++) begin
      measured_current = cur[i];
      ticks(2);
      chk("load", cls[i], load_class);
    end
    measured_current = 16'h0000;
    $display("Test load done");
  endtask

  task automatic t_faults;
    settings.service_factor = 16'h0000;
    settings.k_max_amb = 16'h01f5;
    settings.nominal_scale = 16'h0000;
    settings.max_amb_temp = 16'sh0000;
    ticks(3);
    chk("flags", 4'hf, setting_fault_flag);
    chk("used", {4{`FACTOR_UNITY}}, used_factors);
    settings.service_factor = 16'h0078;
    settings.k_max_amb = 16'h01f4;
    settings.k_min_amb = 16'h0001;
    settings.nominal_scale = 16'h0032;
    settings.max_amb_temp = 16'sh002d;
    ticks(3);
    chk("flags", 4'h0, setting_fault_flag);
    chk("used", {16'h0078, 16'h01f4, 16'h0001, 16'h0032}, used_factors);
    $display("Test faults done");
  endtask

  // Main sequence
  initial begin
    settings = '0;
    settings.alarm1_level = `ALARM1_LEVEL_RST;
    settings.alarm2_level = `ALARM2_LEVEL_RST;
    settings.restart_inhibit_threshold = `INHIBIT_LEVEL_RST;
    settings.trip_level = `TRIP_LEVEL_RST;
    settings.service_factor = `FACTOR_UNITY;
    settings.k_max_amb = `FACTOR_UNITY;
    settings.k_min_amb = `FACTOR_UNITY;
    settings.nominal_scale = `FACTOR_UNITY;
    settings.max_amb_temp = `AMB_MAX_TEMP_RST;
    repeat (12) @(posedge clock);
    #1;
    t_reset;
    t_alarms;
    t_trip;
    t_block;
    t_load;
    t_faults;
    report_and_stop;
  end

  // Watchdog well beyond the expected run of about 15 us
  initial begin
    #200000;
    num_errors++;
    $display("BAD watchdog expected finish seen timeout");
    report_and_stop;
  end
endmodule // thermal_overload_stage_bench
